// *** logic/dacdc_defines.vh ***
// Register map, field positions and constants of the converter control block.
`ifndef DACDC_DEFINES_VH
`define DACDC_DEFINES_VH

// ----------------------------------------------------------------------
// Register word offsets (byte addresses within the block)
// ----------------------------------------------------------------------
`define DACDC_BASE_ADDR 32'h4002_0000
`define DACDC_OFS_CONTROL 4'h0
`define DACDC_OFS_DATA 4'h4
`define DACDC_OFS_IRQ_STATUS 4'h8
`define DACDC_OFS_IRQ_MASK 4'hC

// ----------------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------------
`define DACDC_CTL_RESET 16'h0200
`define DACDC_CTL_WMASK 16'h077F
`define DACDC_CTL_DMA_EN 10
`define DACDC_CTL_POWER_DOWN 9
`define DACDC_CTL_DRIVER_SEL 8
`define DACDC_CTL_BYPASS 6
`define DACDC_CTL_UPDATE_SRC 5
`define DACDC_CTL_CLEAR_N 4
`define DACDC_CTL_INTERP 3
`define DACDC_CTL_RATE 2
`define DACDC_CTL_SPAN_HI 1
`define DACDC_CTL_SPAN_LO 0

// ----------------------------------------------------------------------
// Data register fields and reset value
// ----------------------------------------------------------------------
`define DACDC_DATA_RESET 32'h0000_0000
`define DACDC_DATA_WMASK 32'h0FFF_F000
`define DACDC_MAIN_HI 27
`define DACDC_MAIN_LO 16
`define DACDC_EXTRA_HI 15
`define DACDC_EXTRA_LO 12

// ----------------------------------------------------------------------
// Interrupt bits, divider ratios and the DMA channel number
// ----------------------------------------------------------------------
`define DACDC_IRQ_UPDATE 0
`define DACDC_IRQ_UNDERRUN 1
`define DACDC_DIV_SLOW 6'h20
`define DACDC_DIV_FAST 6'h10
`define DACDC_DMA_CHANNEL 4'h8

`endif

// *** logic/dacdc_fall_det.v ***
// Falling-edge detector for the timer 1 output level.
`timescale 1ns/1ps

module dacdc_fall_det (
  // Clock and reset.
  input wire sys_clk,
  input wire rst,
  // Level in, synchronous to the clock.
  input wire level_in,
  // One-cycle pulse on a high-to-low change.
  output wire fall
);

  reg level_prev;

  // Reset value high would fake an edge if the timer idles low, so reset low.
  always @(posedge sys_clk) begin
    if (rst) begin
      level_prev <= 1'b0;
    end else begin
      level_prev <= level_in;
    end
  end

  assign fall = level_prev && !level_in;

endmodule // dacdc_fall_det

// *** logic/dacdc_interp_div.v ***
// Interpolation clock divider producing a one-cycle enable pulse.
`timescale 1ns/1ps
`include "dacdc_defines.vh"

module dacdc_interp_div (
  // Clock and reset.
  input wire sys_clk,
  input wire rst,
  // Control.
  input wire enable,
  input wire rate_fast,
  // Enable pulse out.
  output reg tick
);

  reg [5:0] count;
  wire [5:0] ratio;

  // Ratio is the undivided clock over 32 or over 16.
  assign ratio = rate_fast ? `DACDC_DIV_FAST : `DACDC_DIV_SLOW;

  // Counter restarts whenever the mode is off so the first pulse is a full period late.
  always @(posedge sys_clk) begin
    if (rst || !enable) begin
      count <= 6'h00;
      tick <= 1'b0;
    end else if (count >= ratio - 6'h01) begin
      count <= 6'h00;
      tick <= 1'b1;
    end else begin
      count <= count + 6'h01;
      tick <= 1'b0;
    end
  end

endmodule // dacdc_interp_div

// *** logic/dacdc_top.v ***
// Digital control of the voltage output converter with register and DMA access.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
`include "dacdc_defines.vh"

module dacdc_top (
  // Clock and reset.
  input wire sys_clk,
  input wire rst,
  // Avalon-MM register slave.
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Timer 1 output level.
  input wire timer1_out,
  // DMA request to the DMA controller.
  output reg dma_req,
  output reg [3:0] dma_channel,
  // Converter core controls.
  output reg [15:0] dac_code,
  output reg dac_load,
  output reg output_power_down,
  output reg output_buffer_bypass,
  output reg transistor_driver_sel,
  output reg [1:0] output_span_sel,
  output reg interp_mode_sel,
  output reg interp_clk_en,
  // Interrupt.
  output reg dac_irq
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------

  // Merges write data into a register by byte lane, keeping only writable bits.
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] lanes;
    input [31:0] wmask;
    reg [31:0] lane_bits;
    begin
      lane_bits = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
      lane_merge = (old_val & ~(lane_bits & wmask)) | (new_val & lane_bits & wmask);
    end
  endfunction

  // Checks that a byte address hits a given register word.
  function hits;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      hits = (addr == ofs);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Registers and internal signals
  // ----------------------------------------------------------------------

  reg [15:0] dac_control;
  reg [31:0] dac_sample_data;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg [1:0] next_status;
  reg [31:0] read_value;
  reg dma_pending;

  wire bus_req;
  wire wr_accept;
  wire wr_control;
  wire wr_data;
  wire wr_status;
  wire wr_mask;
  wire [31:0] ctl_merged;
  wire dma_request_enable;
  wire power_down_bit;
  wire update_src_sel;
  wire output_clear_n;
  wire interp_eff;
  wire interp_rate_sel;
  wire interp_tick;
  wire timer_fall;
  wire update_tick;
  wire [11:0] sample_main_bits;
  wire [3:0] sample_extra_bits;
  wire [15:0] next_code;
  wire underrun;

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------

  // Control fields as stored.
  assign dma_request_enable = dac_control[`DACDC_CTL_DMA_EN];
  assign power_down_bit = dac_control[`DACDC_CTL_POWER_DOWN];
  assign update_src_sel = dac_control[`DACDC_CTL_UPDATE_SRC];
  assign output_clear_n = dac_control[`DACDC_CTL_CLEAR_N];
  assign interp_rate_sel = dac_control[`DACDC_CTL_RATE];

  // Interpolation is refused while the transistor driver is chosen; the core cannot do both.
  assign interp_eff = dac_control[`DACDC_CTL_INTERP]
                      && !dac_control[`DACDC_CTL_DRIVER_SEL];

  // Sample fields of the data register.
  assign sample_main_bits = dac_sample_data[`DACDC_MAIN_HI:`DACDC_MAIN_LO];
  assign sample_extra_bits = dac_sample_data[`DACDC_EXTRA_HI:`DACDC_EXTRA_LO];

  // Extra bits reach the core only in interpolation mode.
  assign next_code = interp_eff ? {sample_main_bits, sample_extra_bits}
                                : {sample_main_bits, 4'h0};

  // ----------------------------------------------------------------------
  // Update timing
  // ----------------------------------------------------------------------

  // The divider is held in reset outside interpolation, so each entry starts a full period.
  dacdc_interp_div u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(interp_eff),
    .rate_fast(interp_rate_sel),
    .tick(interp_tick)
  );

  dacdc_fall_det u_fall (
    .sys_clk(sys_clk),
    .rst(rst),
    .level_in(timer1_out),
    .fall(timer_fall)
  );

  // The undivided clock edge is every cycle here; interpolation paces with its own clock.
  assign update_tick = !power_down_bit && output_clear_n
                       && (interp_eff ? interp_tick
                           : (update_src_sel ? timer_fall : 1'b1));

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------

  // A request is answered one cycle after it appears; write lands on the accepting edge.
  assign bus_req = avs_read || avs_write;
  assign wr_accept = avs_write && !avs_waitrequest;
  assign wr_control = wr_accept && hits(avs_address, `DACDC_OFS_CONTROL);
  assign wr_data = wr_accept && hits(avs_address, `DACDC_OFS_DATA);
  assign wr_status = wr_accept && hits(avs_address, `DACDC_OFS_IRQ_STATUS);
  assign wr_mask = wr_accept && hits(avs_address, `DACDC_OFS_IRQ_MASK);
  assign ctl_merged = lane_merge({16'h0000, dac_control}, avs_writedata,
                                 avs_byteenable, {16'h0000, `DACDC_CTL_WMASK});

  // Read multiplexer; unmapped words and reserved bits read as zero.
  always @* begin
    read_value = 32'h0000_0000;
    case (avs_address)
      `DACDC_OFS_CONTROL: begin
        read_value = {16'h0000, dac_control};
      end
      `DACDC_OFS_DATA: begin
        read_value = dac_sample_data;
      end
      `DACDC_OFS_IRQ_STATUS: begin
        read_value = {30'h0000_0000, irq_status};
      end
      `DACDC_OFS_IRQ_MASK: begin
        read_value = {30'h0000_0000, irq_mask};
      end
      default: begin
        read_value = 32'h0000_0000;
      end
    endcase
  end

  // Waitrequest stays high when idle and drops for exactly one cycle per request.
  always @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (bus_req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? read_value : 32'h0000_0000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Control and data registers
  // ----------------------------------------------------------------------

  // Reserved bits are dropped on the way in, so a read shows what the core sees, except the interpolation bit while the transistor driver is chosen.
  // Control register; only documented bits take writes.
  always @(posedge sys_clk) begin
    if (rst) begin
      dac_control <= `DACDC_CTL_RESET;
    end else if (wr_control) begin
      dac_control <= ctl_merged[15:0];
    end
  end

  // Data register; held at zero while the clear bit is low.
  always @(posedge sys_clk) begin
    if (rst) begin
      dac_sample_data <= `DACDC_DATA_RESET;
    end else if (wr_control && !ctl_merged[`DACDC_CTL_CLEAR_N]) begin
      dac_sample_data <= `DACDC_DATA_RESET;
    end else if (!output_clear_n) begin
      dac_sample_data <= `DACDC_DATA_RESET;
    end else if (wr_data) begin
      dac_sample_data <= lane_merge(dac_sample_data, avs_writedata,
                                    avs_byteenable, `DACDC_DATA_WMASK);
    end
  end

  // ----------------------------------------------------------------------
  // DMA request
  // ----------------------------------------------------------------------

  // A timer event finding the last request still unserved is an underrun.
  assign underrun = dma_request_enable && timer_fall && dma_pending;

  // The request is a level, not a pulse, so a busy controller cannot miss it; a timer
  // event that outruns the controller is flagged rather than queued.
  // One request per timer event, withdrawn by the DMA write into the data word.
  always @(posedge sys_clk) begin
    if (rst) begin
      dma_pending <= 1'b0;
      dma_req <= 1'b0;
      dma_channel <= `DACDC_DMA_CHANNEL;
    end else begin
      dma_channel <= `DACDC_DMA_CHANNEL;
      if (!dma_request_enable) begin
        dma_pending <= 1'b0;
        dma_req <= 1'b0;
      end else if (timer_fall) begin
        dma_pending <= 1'b1;
        dma_req <= 1'b1;
      end else if (wr_data) begin
        dma_pending <= 1'b0;
        dma_req <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Converter outputs
  // ----------------------------------------------------------------------

  // The core code follows the data word only on an update edge; clear zeroes it at once.
  always @(posedge sys_clk) begin
    if (rst) begin
      dac_code <= 16'h0000;
      dac_load <= 1'b0;
    end else if (wr_control && !ctl_merged[`DACDC_CTL_CLEAR_N]) begin
      dac_code <= 16'h0000;
      dac_load <= 1'b1;
    end else if (update_tick) begin
      dac_code <= next_code;
      dac_load <= 1'b1;
    end else begin
      dac_load <= 1'b0;
    end
  end

  // Static configuration and the interpolation tick copied to flip-flops for the analog core.
  always @(posedge sys_clk) begin
    if (rst) begin
      output_power_down <= 1'b1;
      output_buffer_bypass <= 1'b0;
      transistor_driver_sel <= 1'b0;
      output_span_sel <= 2'h0;
      interp_mode_sel <= 1'b0;
      interp_clk_en <= 1'b0;
    end else begin
      output_power_down <= power_down_bit;
      output_buffer_bypass <= dac_control[`DACDC_CTL_BYPASS];
      transistor_driver_sel <= dac_control[`DACDC_CTL_DRIVER_SEL];
      output_span_sel <= dac_control[`DACDC_CTL_SPAN_HI:`DACDC_CTL_SPAN_LO];
      interp_mode_sel <= interp_eff;
      interp_clk_en <= interp_tick;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------

  // Limitation: the update flag sets on every cycle in undivided mode, so mask it there.
  // Sticky status; a new event in the clearing cycle survives the clear.
  always @* begin
    next_status = irq_status;
    if (wr_status && avs_byteenable[0]) begin
      next_status = irq_status & ~avs_writedata[1:0];
    end
    if (update_tick) begin
      next_status[`DACDC_IRQ_UPDATE] = 1'b1;
    end
    if (underrun) begin
      next_status[`DACDC_IRQ_UNDERRUN] = 1'b1;
    end
  end

  // Status, mask and the level interrupt, which is computed from the next values to save a cycle.
  always @(posedge sys_clk) begin
    if (rst) begin
      irq_status <= 2'h0;
      irq_mask <= 2'h0;
      dac_irq <= 1'b0;
    end else begin
      irq_status <= next_status;
      if (wr_mask && avs_byteenable[0]) begin
        irq_mask <= avs_writedata[1:0];
        dac_irq <= |(next_status & avs_writedata[1:0]);
      end else begin
        dac_irq <= |(next_status & irq_mask);
      end
    end
  end

endmodule // dacdc_top

// *** testbench/dacdc_chk.sv ***
// Assertion checker bound to the converter control top module.
`timescale 1ns/1ps
module dacdc_chk (
  // Clock and reset.
  input wire sys_clk,
  input wire rst,
  // Register bus.
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire avs_waitrequest,
  // Converter and DMA outputs.
  input wire [3:0] dma_channel,
  input wire [15:0] dac_code,
  input wire output_power_down,
  input wire output_buffer_bypass,
  input wire transistor_driver_sel,
  input wire [1:0] output_span_sel,
  input wire interp_mode_sel,
  input wire interp_clk_en,
  input wire dac_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Full-word write to the control register, taken at this edge.
  wire ctl_wr = avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable == 4'hF;

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  // Outputs may lag the register by a cycle, so fields are compared two edges on.
  property p_rst;
    $fell(rst) |-> output_power_down && dac_code == 16'h0000 && !dac_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_pd;
    ctl_wr |-> ##2 output_power_down == $past(avs_writedata[9], 2);
  endproperty
  a_pd: assert property (p_pd) else $error("power down mismatch");
  property p_byp;
    ctl_wr |-> ##2 output_buffer_bypass == $past(avs_writedata[6], 2);
  endproperty
  a_byp: assert property (p_byp) else $error("bypass mismatch");
  property p_drv;
    ctl_wr |-> ##2 transistor_driver_sel == $past(avs_writedata[8], 2);
  endproperty
  a_drv: assert property (p_drv) else $error("driver select mismatch");
  property p_span;
    ctl_wr |-> ##2 output_span_sel == $past(avs_writedata[1:0], 2);
  endproperty
  a_span: assert property (p_span) else $error("span mismatch");
  property p_mode;
    ctl_wr |-> ##2 interp_mode_sel == ($past(avs_writedata[3], 2) && !$past(avs_writedata[8], 2));
  endproperty
  a_mode: assert property (p_mode) else $error("interpolation select mismatch");
  property p_clr;
    ctl_wr && !avs_writedata[4] |=> (dac_code == 16'h0000) [*2];
  endproperty
  a_clr: assert property (p_clr) else $error("clear did not zero code");
  property p_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer timing wrong");
  property p_chan;
    dma_channel == 4'h8;
  endproperty
  a_chan: assert property (p_chan) else $error("wrong DMA channel");
  property p_tick;
    interp_clk_en |=> !interp_clk_en [*8];
  endproperty
  a_tick: assert property (p_tick) else $error("interpolation ticks too close");
endmodule // dacdc_chk

bind dacdc_top dacdc_chk u_dacdc_chk (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest), .dma_channel(dma_channel),
  .dac_code(dac_code), .output_power_down(output_power_down), .interp_clk_en(interp_clk_en),
  .output_buffer_bypass(output_buffer_bypass), .transistor_driver_sel(transistor_driver_sel),
  .output_span_sel(output_span_sel), .interp_mode_sel(interp_mode_sel), .dac_irq(dac_irq));

// *** testbench/dacdc_partner.sv ***
// Timer 1 and DMA controller model facing the converter control block.
`timescale 1ns/1ps
module dacdc_partner #(
  parameter int HALF = 20
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Bench controls: timer running, bus granted to DMA.
  input wire logic run,
  input wire logic grant,
  // Block side.
  input wire logic avs_waitrequest,
  input wire logic dma_req,
  output logic timer1_out,
  output logic dma_write,
  output logic [31:0] dma_wdata
);
  logic [5:0] t;
  logic [1:0] hold;
  logic [11:0] smp;

  // Timer toggles every HALF cycles while running; the DMA side stalls without grant.
  always @(posedge sys_clk) begin
    if (rst) begin
      t <= 6'd0;
      timer1_out <= 1'b1;
      dma_write <= 1'b0;
      dma_wdata <= 32'h0000_0000;
      hold <= 2'd0;
      smp <= 12'h000;
    end else begin
      if (run) begin
        t <= (t == HALF - 1) ? 6'd0 : t + 6'd1;
        if (t == HALF - 1)
          timer1_out <= !timer1_out;
      end
      // Hold-off after each word gives the request time to drop.
      if (dma_write) begin
        if (!avs_waitrequest) begin
          dma_write <= 1'b0;
          dma_wdata <= ~dma_wdata;
          hold <= 2'd3;
        end
      end else if (hold != 2'd0)
        hold <= hold - 2'd1;
      else if (grant && dma_req) begin
        dma_write <= 1'b1;
        smp <= smp + 12'h111;
        dma_wdata <= {4'h0, smp + 12'h111, 16'h0000};
      end
    end
  end
endmodule // dacdc_partner

// *** testbench/dacdc_top_tb.sv ***
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module dacdc_top_tb;
  logic sys_clk = 0, rst = 1, tb_wr = 0, tb_rd = 0, run = 0, grant = 0;
  logic [3:0] tb_a = 4'h0;
  logic [31:0] tb_d = 32'h0000_0000, q;
  wire [31:0] avs_readdata, dma_wdata;
  wire avs_waitrequest, dma_req, dma_write, timer1_out, dac_load, output_power_down;
  wire output_buffer_bypass, transistor_driver_sel, interp_mode_sel, interp_clk_en, dac_irq;
  wire [1:0] output_span_sel;
  wire [15:0] dac_code;
  int error_cnt = 0, tests_run = 0, cyc = 0, n, g;
  logic [11:0] smp_exp;

  // Clock and the bus mux; the DMA model owns the bus only while granted.
  always #2.5 sys_clk = ~sys_clk;
  wire avs_write = grant ? dma_write : tb_wr;
  wire [3:0] avs_address = grant ? 4'h4 : tb_a;
  wire [31:0] avs_writedata = grant ? dma_wdata : tb_d;

  dacdc_top u_dacdc_top (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(tb_rd && !grant), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer1_out(timer1_out), .dma_req(dma_req), .dma_channel(), .dac_code(dac_code),
    .dac_load(dac_load), .output_power_down(output_power_down), .dac_irq(dac_irq),
    .output_buffer_bypass(output_buffer_bypass), .transistor_driver_sel(transistor_driver_sel),
    .output_span_sel(output_span_sel), .interp_mode_sel(interp_mode_sel),
    .interp_clk_en(interp_clk_en));
  dacdc_partner u_dacdc_partner (.sys_clk(sys_clk), .rst(rst), .run(run), .grant(grant),
    .avs_waitrequest(avs_waitrequest), .dma_req(dma_req), .timer1_out(timer1_out),
    .dma_write(dma_write), .dma_wdata(dma_wdata));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, s, e);
    end
  endtask

  // One request held until waitrequest is seen low, then one idle edge.
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    tb_wr <= we;
    tb_rd <= !we;
    tb_a <= a;
    tb_d <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    tb_wr <= 1'b0;
    tb_rd <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (2) @(posedge sys_clk);
  endtask

  // Waits, bounded, until the chosen output was high in the last cycle (1: load, 0: tick).
  task automatic wait_hi(input bit sel);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((sel ? dac_load : interp_clk_en) !== 1'b1 && n < 300);
    if ((sel ? dac_load : interp_clk_en) !== 1'b1) begin
      error_cnt++;
      $display("ERROR %0t: wait timed out", $time);
    end
  endtask

  // Timeout: a hang counts as a mismatch.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("ERROR %0t: run timed out", $time);
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    bus(0, 4'h0, 0); chk(q, 32'h0000_0200);
    bus(0, 4'h4, 0); chk(q, 32'h0000_0000);
    bus(0, 4'h2, 0); chk(q, 32'h0000_0000);
    wr(4'h0, 32'hFFFF_FFFF);
    bus(0, 4'h0, 0); chk(q, 32'h0000_077F);
    chk({output_power_down, output_buffer_bypass, transistor_driver_sel}, 3'b111);
    chk(interp_mode_sel, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, i);
      chk(output_span_sel, i);
      chk(output_power_down, 1'b0);
    end
    // Undivided update, data field masking.
    wr(4'h0, 32'h0000_0010);
    wr(4'h4, 32'hFFFF_FFFF);
    bus(0, 4'h4, 0); chk(q, 32'h0FFF_F000);
    wr(4'h4, 32'h0ABC_5000);
    chk(dac_code, 16'hABC0);
    // Interpolation rates and extra bits.
    wr(4'h0, 32'h0000_0018);
    wait_hi(1'b0);
    for (int r = 0; r < 2; r++) begin
      wait_hi(1'b0);
      g = 0;
      do begin
        @(posedge sys_clk);
        g++;
      end while (interp_clk_en !== 1'b1 && g < 99);
      chk(g, r ? 16 : 32);
      chk(dac_code, 16'hABC5);
      wr(4'h0, 32'h0000_001C);
    end
    wr(4'h0, 32'h0000_011C);
    chk({interp_mode_sel, transistor_driver_sel}, 2'b01);
    // Clear, then timer-paced update.
    wr(4'h0, 32'h0000_0000);
    chk(dac_code, 16'h0000);
    bus(0, 4'h4, 0); chk(q, 32'h0000_0000);
    wr(4'h0, 32'h0000_0030);
    wr(4'h4, 32'h0123_4000);
    chk(dac_code, 16'h0000);
    run <= 1'b1;
    wait_hi(1'b1);
    chk(dac_code, 16'h1230);
    run <= 1'b0;
    // DMA stream paced by timer falls.
    wr(4'h0, 32'h0000_0000);
    wr(4'h0, 32'h0000_0430);
    grant <= 1'b1;
    run <= 1'b1;
    smp_exp = 12'h000;
    for (int k = 0; k < 4; k++) begin
      wait_hi(1'b1);
      chk(dac_code, {smp_exp, 4'h0});
      smp_exp = smp_exp + 12'h111;
    end
    chk(u_dacdc_top.dma_channel, 4'h8);
    run <= 1'b0;
    repeat (20) @(posedge sys_clk);
    grant <= 1'b0;
    // Stalled DMA side: a second fall while pending is an underrun.
    run <= 1'b1;
    repeat (200) @(posedge sys_clk);
    run <= 1'b0;
    bus(0, 4'h8, 0); chk(q & 32'h2, 32'h2);
    chk(dma_req, 1'b1);
    wr(4'h0, 32'h0000_0200);
    chk(dma_req, 1'b0);
    wr(4'h8, 32'h0000_0003);
    bus(0, 4'h8, 0); chk(q, 32'h0000_0000);
    // Interrupt raised, masked, cleared.
    wr(4'hC, 32'h0000_0001);
    chk(dac_irq, 1'b0);
    wr(4'h0, 32'h0000_0010);
    wr(4'h0, 32'h0000_0200);
    chk(dac_irq, 1'b1);
    wr(4'hC, 32'h0000_0000);
    chk(dac_irq, 1'b0);
    wr(4'h8, 32'h0000_0001);
    bus(0, 4'h8, 0); chk(q, 32'h0000_0000);
    report_and_stop();
  end
endmodule // dacdc_top_tb
